//--- src/isd_defs.svh
// Offsets, reset values, timing counts and lookup tables for speed detect
`ifndef ISD_DEFS_SVH
`define ISD_DEFS_SVH

// Register offsets within the block (byte addresses)
`define ISD_OFS_CTRL        8'h00
`define ISD_OFS_STATUS      8'h04
`define ISD_OFS_CFG         8'h28
`define ISD_CFG_RESET       32'h0000_0000
`define ISD_OFS_W           8

// Clock and time base
`define ISD_CLK_PERIOD_NS   10
`define ISD_TICK_MS         1
`define ISD_NS_PER_MS       1_000_000
`define ISD_TICK_CYCLES     (`ISD_TICK_MS * `ISD_NS_PER_MS / `ISD_CLK_PERIOD_NS)

// Duration table in ms, code 0 in the low word
`define ISD_MS_LUT {16'h3A98, 16'h2710, 16'h1D4C, 16'h1388, \
                    16'h0FA0, 16'h0BB8, 16'h07D0, 16'h03E8, \
                    16'h02EE, 16'h01F4, 16'h0190, 16'h012C, \
                    16'h00C8, 16'h0064, 16'h0032, 16'h000A}

// Rejoin ratio table in percent of true back-EMF
`define ISD_RATIO_LUT {8'h5A, 8'h55, 8'h50, 8'h4B}

// Forward rejoin speed table in half-percent of rated speed
`define ISD_FWD_LUT {8'hC8, 8'hB4, 8'hA0, 8'h8C, 8'h78, 8'h6E, 8'h64, \
                     8'h5A, 8'h50, 8'h46, 8'h3C, 8'h32, 8'h28, 8'h1E, \
                     8'h14, 8'h0A}

// Reversal handover speed table in half-percent of rated speed
`define ISD_HANDOVER_LUT {8'hC8, 8'hB4, 8'hA0, 8'h8C, 8'h78, 8'h64, \
                          8'h50, 8'h3C, 8'h32, 8'h28, 8'h1E, 8'h19, \
                          8'h14, 8'h0F, 8'h0A, 8'h05}

// Standstill back-EMF table in mV
`define ISD_BEMF_LUT {16'h05DC, 16'h03E8, 16'h02EE, 16'h01F4, \
                      16'h00FA, 16'h0064, 16'h004B, 16'h0032}

// Reversal current table in half-percent of base current
`define ISD_CURR_LUT {8'hC8, 8'hBE, 8'hB4, 8'hAA, 8'hA0, 8'h96, 8'h8C, \
                      8'h78, 8'h6E, 8'h64, 8'h5A, 8'h50, 8'h46, 8'h3C, \
                      8'h37, 8'h32, 8'h2D, 8'h28, 8'h24, 8'h22, 8'h20, \
                      8'h1E, 8'h1C, 8'h1A, 8'h18, 8'h16, 8'h14, 8'h13, \
                      8'h12, 8'h11, 8'h10, 8'h0F}

`endif

//--- src/isd_hold_timer.sv
// Millisecond hold timer for the stop and float phases
`timescale 1ns/1ps
`include "isd_defs.svh"
module isd_hold_timer #(
  parameter int TICK_CYCLES = `ISD_TICK_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [3:0] durCode,
  output logic            expired
);
  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] PRE_TOP = PW'(TICK_CYCLES - 1);
  localparam logic [255:0] MS_LUT = `ISD_MS_LUT;

  logic [PW-1:0] preCnt_r, preCnt_nxt;
  logic [15:0]   msCnt_r, msCnt_nxt;
  logic          busy_r, busy_nxt;
  logic          expired_r, expired_nxt;

  always_comb begin
    preCnt_nxt  = preCnt_r;
    msCnt_nxt   = msCnt_r;
    busy_nxt    = busy_r;
    expired_nxt = expired_r;
    if (load) begin
      msCnt_nxt   = MS_LUT[durCode*16 +: 16];
      preCnt_nxt  = PRE_TOP;
      busy_nxt    = 1'b1;
      expired_nxt = 1'b0;
    end else if (busy_r) begin
      if (preCnt_r == '0) begin
        preCnt_nxt = PRE_TOP;
        msCnt_nxt  = msCnt_r - 16'h0001;
        if (msCnt_r == 16'h0001) begin
          busy_nxt    = 1'b0;
          expired_nxt = 1'b1;
        end
      end else begin
        preCnt_nxt = preCnt_r - PW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      preCnt_r  <= '0;
      msCnt_r   <= 16'h0000;
      busy_r    <= 1'b0;
      expired_r <= 1'b0;
    end else begin
      preCnt_r  <= preCnt_nxt;
      msCnt_r   <= msCnt_nxt;
      busy_r    <= busy_nxt;
      expired_r <= expired_nxt;
    end
  end

  assign expired = expired_r;
endmodule

//--- src/isd_pkg.sv
// Types shared by the speed detect block
package isd_pkg;

  typedef struct packed {
    logic [1:0] backemfRatioForRejoin;
    logic       speedDetectEnable;
    logic       stopEnable;
    logic       floatOutputsEnable;
    logic       reversalEnable;
    logic       rejoinEnable;
    logic [3:0] forwardRejoinSpeedLevel;
    logic       stopExitSelect;
    logic [3:0] stopDuration;
    logic [3:0] floatDuration;
    logic [2:0] standstillBackemfLevel;
    logic [3:0] reversalHandoverSpeed;
    logic [4:0] reversalCurrentLimit;
  } isd_cfg_type;

  // Measurements from the motor datapath, same clock
  typedef struct packed {
    logic        valid;
    logic        forward;
    logic [7:0]  speedHalfPct;
    logic [15:0] bemfMv;
    logic [7:0]  ratioPct;
    logic        stopCurrentMet;
    logic        reverseDone;
  } isd_meas_type;

  typedef enum logic [2:0] {
    ACT_NONE       = 3'b000,
    ACT_SKIP       = 3'b001,
    ACT_STANDSTILL = 3'b010,
    ACT_REJOIN     = 3'b011,
    ACT_REVERSE    = 3'b100,
    ACT_STOP       = 3'b101,
    ACT_FLOAT      = 3'b110
  } isd_action_type;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_MEASURE = 3'b001,
    ST_REJOIN  = 3'b010,
    ST_REVERSE = 3'b011,
    ST_STOP    = 3'b100,
    ST_FLOAT   = 3'b101,
    ST_DONE    = 3'b110
  } isd_state_type;

  // Commands to the gate drive datapath
  typedef struct packed {
    logic           done;
    logic           rejoin;
    logic           reverse;
    logic           stop;
    logic           floatOut;
    isd_action_type action;
    logic [7:0]     handoverSpeed;
    logic [7:0]     currentLimit;
  } isd_cmd_type;

endpackage

//--- src/isd_speed_detect.sv
// Initial speed detection: config register, decision FSM, AHB-Lite slave
//
// What this block does
// - Config word is 32 bits and reads all zero after reset.
// - Bits 31:30 pick rejoin back-EMF ratio 0.75, 0.80, 0.85, 0.90.
// - Bit 29 turns the whole detection on or off.
// - Bit 28 permits the stop (brake) action.
// - Bit 27 permits floating the motor outputs.
// - Bit 26 permits driving a backward motor through reversal.
// - Bit 25 permits rejoining a spinning motor directly.
// - Bits 24:21 give least forward rejoin speed, 5% to 100%.
// - Bit 20 ends stop by time when 0, by current when 1.
// - Bits 19:16 give stop time, 10 ms to 15 s.
// - Bits 11:9 give standstill back-EMF level, 50 mV to 1500 mV.
// - Bits 8:5 give reversal handover speed, 2.5% to 100%.
// - Bits 4:0 give reversal current limit, 7.5% to 100%.
// - Current percentages are relative to the half-scale base current.
// - Speed percentages are relative to rated electrical speed.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "isd_defs.svh"
module isd_speed_detect
  import isd_pkg::*;
#(
  parameter int TICK_CYCLES = `ISD_TICK_CYCLES
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 startReq,
  input  wire isd_pkg::isd_meas_type meas,
  output isd_pkg::isd_cmd_type      cmd
);
  import isd_pkg::*;

  localparam logic [31:0]  RATIO_LUT    = `ISD_RATIO_LUT;
  localparam logic [127:0] FWD_LUT      = `ISD_FWD_LUT;
  localparam logic [127:0] HANDOVER_LUT = `ISD_HANDOVER_LUT;
  localparam logic [127:0] BEMF_LUT     = `ISD_BEMF_LUT;
  localparam logic [255:0] CURR_LUT     = `ISD_CURR_LUT;

  // Bus slave state
  logic                  wrPend_r, wrPend_nxt;
  logic [`ISD_OFS_W-1:0] wrAddr_r, wrAddr_nxt;
  logic [31:0]           hrdata_r, hrdata_nxt;
  logic                  hreadyout_r;
  logic                  hresp_r;
  isd_cfg_type           cfg_r, cfg_nxt;
  logic                  swStart;
  logic                  addrPhase;
  logic [`ISD_OFS_W-1:0] rdAddr;

  // Decision state
  isd_state_type  state_r, state_nxt;
  isd_action_type action_r, action_nxt;
  logic           doneSeen_r, doneSeen_nxt;
  isd_cmd_type    cmd_r, cmd_nxt;
  logic           timerLoad;
  logic [3:0]     timerCode;
  logic           timerExpired;
  logic           start;

  // Decoded thresholds
  logic [7:0]  ratioThr;
  logic [7:0]  fwdThr;
  logic [7:0]  handoverThr;
  logic [15:0] bemfThr;
  logic [7:0]  currLimit;
  logic        standstill;
  logic        rejoinOk;

  assign addrPhase = hsel && htrans[1] && hready;
  assign rdAddr    = haddr[`ISD_OFS_W-1:0];
  assign swStart   = wrPend_r && (wrAddr_r == `ISD_OFS_CTRL) && hwdata[0];

  // Field decode
  assign ratioThr    = RATIO_LUT[cfg_r.backemfRatioForRejoin*8 +: 8];
  assign fwdThr      = FWD_LUT[cfg_r.forwardRejoinSpeedLevel*8 +: 8];
  assign handoverThr = HANDOVER_LUT[cfg_r.reversalHandoverSpeed*8 +: 8];
  assign bemfThr     = BEMF_LUT[cfg_r.standstillBackemfLevel*16 +: 16];
  assign currLimit   = CURR_LUT[cfg_r.reversalCurrentLimit*8 +: 8];

  // Speeds in half-percent of rated speed, current of base current
  assign standstill = meas.bemfMv < bemfThr;
  assign rejoinOk   = meas.forward && cfg_r.rejoinEnable &&
                      (meas.speedHalfPct >= fwdThr) &&
                      (meas.ratioPct >= ratioThr);

  // Register file
  always_comb begin
    wrPend_nxt = addrPhase && hwrite;
    wrAddr_nxt = addrPhase ? rdAddr : wrAddr_r;
    cfg_nxt    = cfg_r;
    hrdata_nxt = hrdata_r;
    if (wrPend_r && (wrAddr_r == `ISD_OFS_CFG)) begin
      cfg_nxt = isd_cfg_type'(hwdata);
    end
    if (addrPhase && !hwrite) begin
      case (rdAddr)
        `ISD_OFS_CFG: begin
          // Forward a write still in its data phase
          if (wrPend_r && (wrAddr_r == `ISD_OFS_CFG)) begin
            hrdata_nxt = hwdata;
          end else begin
            hrdata_nxt = 32'(cfg_r);
          end
        end
        `ISD_OFS_STATUS: begin
          hrdata_nxt = {23'h00_0000, doneSeen_r, 1'b0, action_r,
                        1'b0, state_r};
        end
        default: begin
          hrdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPend_r    <= 1'b0;
      wrAddr_r    <= '0;
      hrdata_r    <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      cfg_r       <= isd_cfg_type'(`ISD_CFG_RESET);
    end else begin
      wrPend_r    <= wrPend_nxt;
      wrAddr_r    <= wrAddr_nxt;
      hrdata_r    <= hrdata_nxt;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      cfg_r       <= cfg_nxt;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;

  // Decision sequence
  assign start = startReq || swStart;

  always_comb begin
    state_nxt    = state_r;
    action_nxt   = action_r;
    doneSeen_nxt = doneSeen_r;
    timerLoad    = 1'b0;
    timerCode    = cfg_r.stopDuration;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          doneSeen_nxt = 1'b0;
          if (!cfg_r.speedDetectEnable) begin
            state_nxt  = ST_DONE;
            action_nxt = ACT_SKIP;
          end else begin
            state_nxt  = ST_MEASURE;
            action_nxt = ACT_NONE;
          end
        end
      end
      ST_MEASURE: begin
        if (meas.valid) begin
          if (standstill) begin
            state_nxt  = ST_DONE;
            action_nxt = ACT_STANDSTILL;
          end else if (rejoinOk) begin
            state_nxt  = ST_REJOIN;
            action_nxt = ACT_REJOIN;
          end else if (!meas.forward && cfg_r.reversalEnable) begin
            state_nxt  = ST_REVERSE;
            action_nxt = ACT_REVERSE;
          end else if (cfg_r.stopEnable) begin
            state_nxt  = ST_STOP;
            action_nxt = ACT_STOP;
            timerLoad  = 1'b1;
            timerCode  = cfg_r.stopDuration;
          end else if (cfg_r.floatOutputsEnable) begin
            state_nxt  = ST_FLOAT;
            action_nxt = ACT_FLOAT;
            timerLoad  = 1'b1;
            timerCode  = cfg_r.floatDuration;
          end else begin
            state_nxt  = ST_DONE;
            action_nxt = ACT_NONE;
          end
        end
      end
      ST_REJOIN: begin
        state_nxt = ST_DONE;
      end
      ST_REVERSE: begin
        if (meas.reverseDone) begin
          state_nxt = ST_DONE;
        end
      end
      ST_STOP: begin
        if (cfg_r.stopExitSelect ? meas.stopCurrentMet
                                 : timerExpired) begin
          state_nxt = ST_DONE;
        end
      end
      ST_FLOAT: begin
        if (timerExpired) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt    = ST_IDLE;
        doneSeen_nxt = 1'b1;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Commands follow the next state so they line up with state_r
  always_comb begin
    cmd_nxt               = '0;
    cmd_nxt.done          = (state_nxt == ST_DONE);
    cmd_nxt.rejoin        = (state_nxt == ST_REJOIN);
    cmd_nxt.reverse       = (state_nxt == ST_REVERSE);
    cmd_nxt.stop          = (state_nxt == ST_STOP);
    cmd_nxt.floatOut      = (state_nxt == ST_FLOAT);
    cmd_nxt.action        = action_nxt;
    cmd_nxt.handoverSpeed = handoverThr;
    cmd_nxt.currentLimit  = currLimit;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      action_r   <= ACT_NONE;
      doneSeen_r <= 1'b0;
      cmd_r      <= '0;
    end else begin
      state_r    <= state_nxt;
      action_r   <= action_nxt;
      doneSeen_r <= doneSeen_nxt;
      cmd_r      <= cmd_nxt;
    end
  end

  assign cmd = cmd_r;

  isd_hold_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (timerLoad),
    .durCode (timerCode),
    .expired (timerExpired)
  );

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_cfg_write_lands: assert property (
    (wrPend_r && wrAddr_r == `ISD_OFS_CFG) |=> 32'(cfg_r) == $past(hwdata))
    else $error("config write not stored");

  a_disabled_skips: assert property (
    (state_r == ST_IDLE && start && !cfg_r.speedDetectEnable)
      |=> (state_r == ST_DONE && action_r == ACT_SKIP && cmd.done)
          ##1 !cmd.done)
    else $error("disabled detection did not skip");

  a_stop_gated: assert property (
    (state_r == ST_MEASURE && meas.valid && !cfg_r.stopEnable)
      |=> state_r != ST_STOP)
    else $error("stop taken while not permitted");

  a_float_gated: assert property (
    (state_r == ST_MEASURE && meas.valid && !cfg_r.floatOutputsEnable)
      |=> !cmd.floatOut)
    else $error("float taken while not permitted");

  a_reverse_gated: assert property (
    (state_r == ST_MEASURE && meas.valid && !cfg_r.reversalEnable)
      |=> !cmd.reverse)
    else $error("reversal taken while not permitted");

  a_rejoin_gated: assert property (
    (state_r == ST_MEASURE && meas.valid && !cfg_r.rejoinEnable)
      |=> !cmd.rejoin)
    else $error("rejoin taken while not permitted");

  a_rejoin_thresholds: assert property (
    (state_r == ST_MEASURE && meas.valid &&
     (meas.speedHalfPct < fwdThr || meas.ratioPct < ratioThr))
      |=> !cmd.rejoin)
    else $error("rejoin taken below its thresholds");

  a_rejoin_pulse: assert property (
    cmd.rejoin |-> ##1 (!cmd.rejoin && cmd.done && cmd.action == ACT_REJOIN))
    else $error("rejoin command not a single pulse");

  a_stop_current_exit: assert property (
    (state_r == ST_STOP && cfg_r.stopExitSelect && meas.stopCurrentMet)
      |=> state_r == ST_DONE && cmd.done)
    else $error("stop did not end on current");

  a_stop_time_exit: assert property (
    (state_r == ST_STOP && !cfg_r.stopExitSelect && !timerExpired)
      |=> state_r inside {ST_STOP})
    else $error("stop ended before its time");

  a_standstill_first: assert property (
    (state_r == ST_MEASURE && meas.valid && standstill)
      |=> action_r == ACT_STANDSTILL && !cmd.rejoin && !cmd.reverse)
    else $error("standstill not detected first");

  a_current_limit: assert property (
    (state_r == ST_REVERSE && $stable(cfg_r))
      |-> cmd.currentLimit == CURR_LUT[cfg_r.reversalCurrentLimit*8 +: 8])
    else $error("reversal current limit wrong");

  c_rejoin:  cover property (state_r == ST_REJOIN);
  c_reverse: cover property (state_r == ST_REVERSE ##[1:20] state_r == ST_DONE);
  c_stop:    cover property (state_r == ST_STOP ##1 state_r == ST_DONE);
  c_float:   cover property (state_r == ST_FLOAT ##1 state_r == ST_DONE);
endmodule

//--- tb/isd_motor_model.sv
// Motor and measurement datapath model facing the speed detect block
`timescale 1ns/1ps
module isd_motor_model #(
  parameter int REV_CYCLES = 20,
  parameter int CUR_CYCLES = 30
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire isd_pkg::isd_cmd_type  cmd,
  input  wire logic                  measOn,
  input  wire logic                  fwd,
  input  wire logic [7:0]            speed,
  input  wire logic [15:0]           bemf,
  input  wire logic [7:0]            ratio,
  output isd_pkg::isd_meas_type      meas
);
  import isd_pkg::*;
  int   cnt_r;
  logic tog_r;
  // Cycles spent reversing or braking, as the motor slows down
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 0;
      tog_r <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
      cnt_r <= (cmd.reverse || cmd.stop) ? cnt_r + 1 : 0;
    end
  end
  // Outside a measurement the lines carry a changing pattern
  always_comb begin
    meas.valid          = measOn;
    meas.forward        = measOn ? fwd : tog_r;
    meas.speedHalfPct   = measOn ? speed : {4{tog_r, ~tog_r}};
    meas.bemfMv         = measOn ? bemf : {8{tog_r, ~tog_r}};
    meas.ratioPct       = measOn ? ratio : {4{~tog_r, tog_r}};
    meas.reverseDone    = cmd.reverse && (cnt_r >= REV_CYCLES);
    meas.stopCurrentMet = cmd.stop && (cnt_r >= CUR_CYCLES);
  end
endmodule

//--- tb/tb_top.sv
// Self-checking testbench for the speed detect block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  import isd_pkg::*;
  localparam int TICK = 10;
  localparam int LIMIT = 20000;
  logic              clk_sys, rst, hsel, hwrite, startReq;
  logic [31:0]       haddr, hwdata, hrdata, rd;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              hreadyout, hresp, measOn, fwd;
  logic [7:0]        speed, ratio;
  logic [15:0]       bemf;
  isd_meas_type      meas;
  isd_cmd_type       cmd;
  int                n_mismatch, checks, cyc;
  logic [7:0] hand[16] = '{5, 10, 15, 20, 25, 30, 40, 50, 60, 80, 100,
                           120, 140, 160, 180, 200};
  logic [7:0] curr[32] = '{15, 16, 17, 18, 19, 20, 22, 24, 26, 28, 30,
                           32, 34, 36, 40, 45, 50, 55, 60, 70, 80, 90,
                           100, 110, 120, 140, 150, 160, 170, 180, 190,
                           200};

  isd_speed_detect #(.TICK_CYCLES(TICK)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .startReq(startReq), .meas(meas), .cmd(cmd));

  isd_motor_model i_motor (
    .clk_sys(clk_sys), .rst(rst), .cmd(cmd), .measOn(measOn),
    .fwd(fwd), .speed(speed), .bemf(bemf), .ratio(ratio), .meas(meas));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h0000_0000;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Runs one detection and checks the decision and how long it acted
  task automatic run(input logic [31:0] cfg, input logic f,
                     input logic [7:0] s, input logic [15:0] b,
                     input logic [7:0] r, input isd_action_type act,
                     input int lo, input int hi);
    int len;
    int nRej;
    len  = 0;
    nRej = 0;
    bus(1'b1, 32'h0000_0028, cfg);
    fwd    <= f;
    speed  <= s;
    bemf   <= b;
    ratio  <= r;
    measOn <= 1'b1;
    @(posedge clk_sys);
    startReq <= 1'b1;
    @(posedge clk_sys);
    startReq <= 1'b0;
    #1;
    while (cmd.done !== 1'b1 && len < 5000) begin
      if (cmd.stop || cmd.floatOut || cmd.reverse)
        len++;
      if (cmd.rejoin === 1'b1)
        nRej++;
      @(posedge clk_sys);
      #1;
    end
    `CHK(cmd.action, act)
    `CHK(nRej, int'(act == ACT_REJOIN))
    `CHK(int'(len >= lo && len <= hi), 1)
    @(posedge clk_sys);
    measOn <= 1'b0;
  endtask

  initial begin
    n_mismatch = 0;
    checks = 0;
    cyc = 0;
    rst = 1'b1;
    {hsel, hwrite, startReq, measOn, fwd} = '0;
    haddr = '0;
    hwdata = '0;
    htrans = 2'b00;
    hsize = 3'b010;
    speed = '0;
    ratio = '0;
    bemf = '0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    hsel <= 1'b1;
    settle(1);
    `CHK(cmd, isd_cmd_type'(24'h00_050F))
    `CHK({hreadyout, hresp}, 2'b10)
    bus(1'b0, 32'h0000_0028, 0);
    `CHK(rd, 32'h0000_0000)
    bus(1'b1, 32'h0000_0028, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0028, 0);
    `CHK(rd, 32'hFFFF_FFFF)
    bus(1'b1, 32'h0000_0028, 32'h5A5A_A5A5);
    bus(1'b0, 32'h0000_0028, 0);
    `CHK(rd, 32'h5A5A_A5A5)
    bus(1'b0, 32'h0000_003C, 0);
    `CHK(rd, 32'h0000_0000)
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, 32'h0000_0028, 32'(i) << 5);
      settle(2);
      `CHK(cmd.handoverSpeed, hand[i])
    end
    for (int i = 0; i < 32; i++) begin
      bus(1'b1, 32'h0000_0028, 32'(i));
      settle(2);
      `CHK(cmd.currentLimit, curr[i])
    end
    // Detection switched off, started from software
    bus(1'b1, 32'h0000_0028, 32'hDFFF_FFFF);
    bus(1'b1, 32'h0000_0000, 32'h0000_0001);
    settle(3);
    bus(1'b0, 32'h0000_0004, 0);
    `CHK(rd[6:4], ACT_SKIP)
    `CHK(rd[8], 1'b1)
    `CHK(rd[2:0], 3'b000)
    run(32'h0000_0000, 1, 0, 0, 0, ACT_SKIP, 0, 0);
    run(32'h2000_0600, 1, 0, 249, 0, ACT_STANDSTILL, 0, 0);
    run(32'h2000_0600, 1, 0, 250, 0, ACT_NONE, 0, 0);
    run(32'h2000_0000, 1, 0, 49, 0, ACT_STANDSTILL, 0, 0);
    run(32'h2000_0E00, 1, 0, 1499, 0, ACT_STANDSTILL, 0, 0);
    run(32'hE3E0_0000, 1, 200, 1000, 90, ACT_REJOIN, 0, 0);
    run(32'hE3E0_0000, 1, 199, 1000, 90, ACT_NONE, 0, 0);
    run(32'hE3E0_0000, 1, 200, 1000, 89, ACT_NONE, 0, 0);
    run(32'h2200_0000, 1, 10, 1000, 75, ACT_REJOIN, 0, 0);
    run(32'h2000_0000, 1, 10, 1000, 75, ACT_NONE, 0, 0);
    run(32'h2400_0000, 0, 50, 1000, 90, ACT_REVERSE, 20, 25);
    run(32'h3000_0000, 0, 50, 1000, 90, ACT_STOP, 100, 103);
    run(32'h3010_0000, 1, 50, 1000, 90, ACT_STOP, 30, 35);
    run(32'h2800_1000, 1, 50, 1000, 90, ACT_FLOAT, 500, 503);
    run(32'h2000_1000, 0, 50, 1000, 90, ACT_NONE, 0, 0);
    conclude();
  end
endmodule
